//--- design/zdis_regs.vh
// Register offsets, field positions, reset values and codes for the zero delay input select block.
// Assumes a byte-wide register port addressed by the 16-bit register address, included by bare name.
//
// Notes on behaviour
// [R1] Zero delay operation runs only while the enable bit is 1; reset value is 0.
// [R2] When enabled, internal PLL feedback opens and the external feedback input is used.
// [R3] Zero delay mode never chooses inputs automatically; pins or registers choose manually.
// [R4] Choice-source bit 0 selects pins, 1 selects a register field; reset is 0.
// [R5] Zero delay choice code 0,1,2 picks inputs 0,1,2; code 3 reserved.
// [R6] Enabled with register control uses the zero delay field, ignoring pins and normal register.
// [R7] Choice source resolves from enable and source bits per the four-entry table.
// [R8] While zero delay operation is active, input switching is never hitless.
// [R9] Twelve-bit force-on field over two registers; 0x800 keeps feedback driver on.
// [R10] Reserved code 3 under register control keeps the previously selected input.
`ifndef ZDIS_REGS_VH
`define ZDIS_REGS_VH

`define ZDIS_ADDR_FORCE_LO 16'h013F
`define ZDIS_ADDR_FORCE_HI 16'h0140
`define ZDIS_ADDR_ZD_CTRL 16'h0487
`define ZDIS_ADDR_SRC_CTRL 16'h052A

`define ZDIS_RST_FORCE_LO 8'h00
`define ZDIS_RST_FORCE_HI 4'h0
`define ZDIS_RST_ZD_CTRL 3'h0
`define ZDIS_RST_SRC_CTRL 1'h0

`define ZDIS_BIT_ZD_EN 0
`define ZDIS_BIT_CHOICE_LSB 1
`define ZDIS_BIT_CHOICE_MSB 2
`define ZDIS_BIT_SRC 0

`define ZDIS_FORCE_FEEDBACK 12'h800
`define ZDIS_FEEDBACK_BIT 11
`define ZDIS_CHOICE_RESERVED 2'h3
`define ZDIS_INPUT_RESET 2'h0

`endif

//--- design/zdis_sync2.v
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes the destination clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module zdis_sync2 #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Data
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // zdis_sync2

//--- design/zdis_top.v
// Zero delay mode control: register bank, input clock choice and feedback controls.
// Assumes a synchronous byte register port on CLOCK; select pins are asynchronous.
`timescale 1ns/1ps
`include "zdis_regs.vh"
module zdis_top (
  // Clock and reset
  input wire CLOCK,
  input wire RSTN,
  // Register port
  input wire [15:0] REG_ADDR,
  input wire REG_WR,
  input wire [7:0] REG_WDATA,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  // Input choice pins
  input wire INPUT_CHOICE_PIN_HI,
  input wire INPUT_CHOICE_PIN_LO,
  // Normal input choice from the rest of the device
  input wire [1:0] NORMAL_INPUT_CHOICE,
  // Clock path controls
  output reg [1:0] SELECTED_INPUT,
  output reg ZERO_DELAY_MODE,
  output reg USE_EXTERNAL_FEEDBACK,
  output reg INTERNAL_FEEDBACK_OPEN,
  output reg AUTO_SELECT_ALLOWED,
  output reg HITLESS_SWITCH_ALLOWED,
  output reg [11:0] OUTPUT_FORCE_ON_MASK,
  output reg FEEDBACK_OUTPUT_DRIVER_ON
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] output_force_on_low;
  reg [3:0] output_force_on_high;
  reg [2:0] zero_delay_control;
  reg input_choice_source;
  wire [1:0] pin_choice;
  wire zero_delay_enable;
  wire [1:0] zero_delay_input_choice;
  reg [1:0] next_selected;
  reg [7:0] next_rdata;
  // Write strobes, one per mapped register
  wire wr_force_lo;
  wire wr_force_hi;
  wire wr_zd_ctrl;
  wire wr_src_ctrl;
  // Which control governs the input choice
  localparam GOV_PINS = 2'b00;
  localparam GOV_NORMAL = 2'b01;
  localparam GOV_ZD_FIELD = 2'b10;
  reg [1:0] governing_source;
  // Next values of the clock path controls
  reg next_zero_delay_mode;
  reg next_use_external_feedback;
  reg next_internal_feedback_open;
  reg next_auto_select_allowed;
  reg next_hitless_switch_allowed;
  reg [11:0] next_force_on_mask;
  reg next_feedback_driver_on;

  assign zero_delay_enable = zero_delay_control[`ZDIS_BIT_ZD_EN];
  assign zero_delay_input_choice = zero_delay_control[`ZDIS_BIT_CHOICE_MSB:`ZDIS_BIT_CHOICE_LSB];
  // Unmapped addresses raise no strobe, so such writes are dropped
  assign wr_force_lo = REG_WR && (REG_ADDR == `ZDIS_ADDR_FORCE_LO);
  assign wr_force_hi = REG_WR && (REG_ADDR == `ZDIS_ADDR_FORCE_HI);
  assign wr_zd_ctrl = REG_WR && (REG_ADDR == `ZDIS_ADDR_ZD_CTRL);
  assign wr_src_ctrl = REG_WR && (REG_ADDR == `ZDIS_ADDR_SRC_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  // One process per register, so a stray strobe cannot disturb its neighbours
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      output_force_on_low <= `ZDIS_RST_FORCE_LO;
    end else if (wr_force_lo) begin
      output_force_on_low <= REG_WDATA; // [R9]
    end
  end

  // Upper nibble of the write data is dropped
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      output_force_on_high <= `ZDIS_RST_FORCE_HI;
    end else if (wr_force_hi) begin
      output_force_on_high <= REG_WDATA[3:0]; // [R9]
    end
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      zero_delay_control <= `ZDIS_RST_ZD_CTRL; // [R1]
    end else if (wr_zd_ctrl) begin
      zero_delay_control <= REG_WDATA[2:0]; // [R5]
    end
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      input_choice_source <= `ZDIS_RST_SRC_CTRL; // [R4]
    end else if (wr_src_ctrl) begin
      input_choice_source <= REG_WDATA[`ZDIS_BIT_SRC]; // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back

  // Unmapped addresses and unused bits read as zero
  always @* begin
    next_rdata = 8'h00;
    case (REG_ADDR)
      `ZDIS_ADDR_FORCE_LO: next_rdata = output_force_on_low;
      `ZDIS_ADDR_FORCE_HI: next_rdata = {4'h0, output_force_on_high};
      `ZDIS_ADDR_ZD_CTRL: next_rdata = {5'h00, zero_delay_control};
      `ZDIS_ADDR_SRC_CTRL: next_rdata = {7'h00, input_choice_source};
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  zdis_sync2 #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(CLOCK),
    .rst_n(RSTN),
    .d({INPUT_CHOICE_PIN_HI, INPUT_CHOICE_PIN_LO}),
    .q(pin_choice)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Input choice
  // Pins can still reach code 3; downstream treats that as the pin's own choice
  always @* begin
    governing_source = GOV_PINS;
    case ({zero_delay_enable, input_choice_source}) // [R7]
      2'b00: governing_source = GOV_PINS;
      2'b01: governing_source = GOV_NORMAL;
      2'b10: governing_source = GOV_PINS; // [R3]
      2'b11: governing_source = GOV_ZD_FIELD; // [R6]
      default: governing_source = GOV_PINS;
    endcase
  end

  always @* begin
    next_selected = SELECTED_INPUT;
    case (governing_source)
      GOV_PINS: next_selected = pin_choice; // [R4]
      GOV_NORMAL: next_selected = NORMAL_INPUT_CHOICE;
      GOV_ZD_FIELD: begin
        // Reserved code would pick the feedback input; hold instead
        if (zero_delay_input_choice != `ZDIS_CHOICE_RESERVED) begin // [R10]
          next_selected = zero_delay_input_choice; // [R5] [R6]
        end
      end
      default: next_selected = SELECTED_INPUT;
    endcase
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      SELECTED_INPUT <= `ZDIS_INPUT_RESET;
    end else begin
      SELECTED_INPUT <= next_selected;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and feedback controls
  // A register stage keeps each control free of decode glitches at the clock path
  always @* begin
    next_zero_delay_mode = zero_delay_enable; // [R1]
    next_use_external_feedback = zero_delay_enable; // [R2]
    next_internal_feedback_open = zero_delay_enable; // [R2]
    next_auto_select_allowed = ~zero_delay_enable; // [R3]
    next_hitless_switch_allowed = ~zero_delay_enable; // [R8]
    next_force_on_mask = {output_force_on_high, output_force_on_low}; // [R9]
    next_feedback_driver_on = next_force_on_mask[`ZDIS_FEEDBACK_BIT]; // [R9]
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ZERO_DELAY_MODE <= 1'b0;
      USE_EXTERNAL_FEEDBACK <= 1'b0;
      INTERNAL_FEEDBACK_OPEN <= 1'b0;
    end else begin
      ZERO_DELAY_MODE <= next_zero_delay_mode; // [R1]
      USE_EXTERNAL_FEEDBACK <= next_use_external_feedback; // [R2]
      INTERNAL_FEEDBACK_OPEN <= next_internal_feedback_open; // [R2]
    end
  end

  // Outside the mode, automatic and hitless switching stay available
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      AUTO_SELECT_ALLOWED <= 1'b1;
      HITLESS_SWITCH_ALLOWED <= 1'b1;
    end else begin
      AUTO_SELECT_ALLOWED <= next_auto_select_allowed; // [R3]
      HITLESS_SWITCH_ALLOWED <= next_hitless_switch_allowed; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output force-on mask
  // The two halves are written apart, so the mask may show a mixed value until the second half is written
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      OUTPUT_FORCE_ON_MASK <= {`ZDIS_RST_FORCE_HI, `ZDIS_RST_FORCE_LO};
      FEEDBACK_OUTPUT_DRIVER_ON <= 1'b0;
    end else begin
      OUTPUT_FORCE_ON_MASK <= next_force_on_mask; // [R9]
      FEEDBACK_OUTPUT_DRIVER_ON <= next_feedback_driver_on; // [R9]
    end
  end
endmodule // zdis_top

//--- sim/zdis_src_model.sv
// Model of the select pin drivers facing the block.
// Assumes the bench asks for a pin code on CLOCK.
`timescale 1ns/1ps
module zdis_src_model (
  input wire CLOCK,
  input wire [1:0] want,
  output logic hi,
  output logic lo
);
  always @(posedge CLOCK) {hi, lo} <= want;
endmodule // zdis_src_model

//--- sim/zdis_asserts.sv
// Port checker for the zero delay input select block.
// Assumes it is bound to zdis_top.
`timescale 1ns/1ps
module zdis_asserts (
  // Clock, reset and register port
  input wire CLOCK, RSTN, REG_WR,
  input wire [15:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  // Controls
  input wire ZERO_DELAY_MODE, USE_EXTERNAL_FEEDBACK, INTERNAL_FEEDBACK_OPEN,
  input wire AUTO_SELECT_ALLOWED, HITLESS_SWITCH_ALLOWED, FEEDBACK_OUTPUT_DRIVER_ON,
  input wire [11:0] OUTPUT_FORCE_ON_MASK
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  property p_ext; ZERO_DELAY_MODE == USE_EXTERNAL_FEEDBACK; endproperty
  a_ext: assert property (p_ext) else $error("feedback source wrong");
  property p_open; INTERNAL_FEEDBACK_OPEN == USE_EXTERNAL_FEEDBACK; endproperty
  a_open: assert property (p_open) else $error("loop open wrong");
  property p_auto; AUTO_SELECT_ALLOWED != ZERO_DELAY_MODE; endproperty
  a_auto: assert property (p_auto) else $error("auto choice wrong");
  property p_hit; ZERO_DELAY_MODE |-> !HITLESS_SWITCH_ALLOWED; endproperty
  a_hit: assert property (p_hit) else $error("hitless in mode");
  property p_fb; OUTPUT_FORCE_ON_MASK[11] [*2] |-> FEEDBACK_OUTPUT_DRIVER_ON; endproperty
  a_fb: assert property (p_fb) else $error("driver not forced");
  property p_en;
    logic [7:0] d;
    (REG_WR && REG_ADDR == 16'h0487, d = REG_WDATA) |-> ##2 ZERO_DELAY_MODE == d[0];
  endproperty
  a_en: assert property (p_en) else $error("mode not from enable");
  property p_lo;
    logic [7:0] d;
    (REG_WR && REG_ADDR == 16'h013F, d = REG_WDATA) |-> ##2 OUTPUT_FORCE_ON_MASK[7:0] == d;
  endproperty
  a_lo: assert property (p_lo) else $error("mask low wrong");
  property p_hi;
    logic [7:0] d;
    (REG_WR && REG_ADDR == 16'h0140, d = REG_WDATA) |-> ##2 OUTPUT_FORCE_ON_MASK[11:8] == d[3:0];
  endproperty
  a_hi: assert property (p_hi) else $error("mask high wrong");
  cover property (ZERO_DELAY_MODE && FEEDBACK_OUTPUT_DRIVER_ON);
  cover property ($fell(ZERO_DELAY_MODE));
  cover property ($rose(ZERO_DELAY_MODE));
endmodule // zdis_asserts
bind zdis_top zdis_asserts chk (.CLOCK, .RSTN, .REG_WR, .REG_ADDR, .REG_WDATA, .ZERO_DELAY_MODE,
  .USE_EXTERNAL_FEEDBACK, .INTERNAL_FEEDBACK_OPEN, .AUTO_SELECT_ALLOWED, .HITLESS_SWITCH_ALLOWED,
  .FEEDBACK_OUTPUT_DRIVER_ON, .OUTPUT_FORCE_ON_MASK);

//--- sim/tb_top.sv
// Bench: register and input choice checks for the zero delay block.
// Assumes design/ is on the include path.
`timescale 1ns/1ps
module tb_top;
  logic CLOCK = 0, RSTN = 0, REG_WR = 0, REG_RD = 0, hi, lo, zero_delay_mode, ext, opn, aut, hit, fbo;
  logic [15:0] REG_ADDR = 0;
  logic [7:0] REG_WDATA = 0, rdat;
  logic [1:0] want = 0, norm = 0, sel, f, e;
  logic [11:0] msk;
  int num_errors = 0, checked = 0, cyc = 0;
  always #20 CLOCK = ~CLOCK;
  zdis_src_model src (.CLOCK, .want, .hi, .lo);
  zdis_top dut (.CLOCK, .RSTN, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA(rdat),
    .INPUT_CHOICE_PIN_HI(hi), .INPUT_CHOICE_PIN_LO(lo), .NORMAL_INPUT_CHOICE(norm), .SELECTED_INPUT(sel),
    .ZERO_DELAY_MODE(zero_delay_mode), .USE_EXTERNAL_FEEDBACK(ext), .INTERNAL_FEEDBACK_OPEN(opn),
    .AUTO_SELECT_ALLOWED(aut), .HITLESS_SWITCH_ALLOWED(hit), .OUTPUT_FORCE_ON_MASK(msk),
    .FEEDBACK_OUTPUT_DRIVER_ON(fbo));
  task ck(input logic [15:0] x, input logic [15:0] g);
    checked++;
    if (x !== g) begin
      num_errors++;
      $display("BAD %0t %h %h", $time, x, g);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLOCK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
    @(posedge CLOCK) REG_WR <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] x);
    @(posedge CLOCK) {REG_RD, REG_ADDR} <= {1'b1, a};
    @(posedge CLOCK) REG_RD <= 1'b0;
    #1 ck(x, rdat);
  endtask
  // Pins pass two sync flops, so four edges cover every path
  task settle;
    repeat (4) @(posedge CLOCK);
    #1;
  endtask
  task tally_and_finish;
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(posedge CLOCK);
    RSTN <= 1'b1;
    rd(16'h013F, 8'h00);
    rd(16'h0140, 8'h00);
    rd(16'h0487, 8'h00);
    rd(16'h052A, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(16'h052A, {7'h00, m[0]});
      for (int p = 0; p < 3; p++) begin
        want <= p[1:0];
        norm <= 2'h2 - p[1:0];
        f = (p[1:0] == 2'h2) ? 2'h0 : p[1:0] + 2'h1;
        wr(16'h0487, {5'h00, f, m[1]});
        settle;
        e = (m == 1) ? norm : (m == 3) ? f : want;
        ck(e, sel);
        ck({5{m[1]}} ^ 5'h03, {zero_delay_mode, ext, opn, aut, hit});
      end
    end
    wr(16'h0487, 8'h05);
    wr(16'h0487, 8'h07);
    settle;
    ck(2'h2, sel);
    rd(16'h0487, 8'h07);
    wr(16'h0486, 8'hFE);
    rd(16'h0487, 8'h07);
    rd(16'h0486, 8'h00);
    wr(16'h0140, 8'hF8);
    wr(16'h013F, 8'h00);
    settle;
    ck({12'h800, 1'b1}, {msk, fbo});
    rd(16'h0140, 8'h08);
    RSTN <= 1'b0;
    settle;
    RSTN <= 1'b1;
    rd(16'h0487, 8'h00);
    ck(13'h0000, {msk, fbo});
    ck(5'h03, {zero_delay_mode, ext, opn, aut, hit});
    settle;
    ck(2'h2, sel);
    tally_and_finish;
  end
endmodule // tb_top
